/* File: logic/pat_pkg.sv */
// constants shared by the auto-reload pwm timer and its capture channels
package pat_pkg;

	// ===========================================
	// widths and counts
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PRESC_W = 7;
	localparam int NUM_PWM = 4;
	localparam int NUM_CAP = 2;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ===========================================
	// register offsets
	localparam logic [7:0] OFF_DUTY3 = 8'h73;
	localparam logic [7:0] OFF_DUTY2 = 8'h74;
	localparam logic [7:0] OFF_DUTY1 = 8'h75;
	localparam logic [7:0] OFF_DUTY0 = 8'h76;
	localparam logic [7:0] OFF_PWMCTL = 8'h77;
	localparam logic [7:0] OFF_TCS = 8'h78;
	localparam logic [7:0] OFF_CNT = 8'h79;
	localparam logic [7:0] OFF_RELOAD = 8'h7A;
	localparam logic [7:0] OFF_CCS = 8'h7B;
	localparam logic [7:0] OFF_CAP1 = 8'h7C;
	localparam logic [7:0] OFF_CAP2 = 8'h7D;

	// ===========================================
	// timer_control_status fields
	localparam int EXT_SEL_BIT = 7;
	localparam int DIV_LSB = 4;
	localparam int EN_BIT = 3;
	localparam int FRC_BIT = 2;
	localparam int OIE_BIT = 1;
	localparam int OVF_BIT = 0;

	// ===========================================
	// pwm_output_control and capture_control_status fields
	localparam int OE_LSB = 4;
	localparam int POL_LSB = 0;
	localparam int CS_LSB = 4;
	localparam int CIE_LSB = 2;
	localparam int CF_LSB = 0;

endpackage

/* File: logic/pat_cap_if.sv */
// link between the timer core and one capture channel
`timescale 1ns/10ps
interface pat_cap_if;
	logic [7:0] count;
	logic rise_sel;
	logic rd_clr;
	logic flag;
	logic [7:0] data;
	modport timer (output count, output rise_sel, output rd_clr, input flag, input data);
	modport channel (input count, input rise_sel, input rd_clr, output flag, output data);
endinterface

/* File: logic/pat_capture.sv */
// one input capture channel: pin synchroniser, edge select, flag and held value
`timescale 1ns/10ps
module pat_capture (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// capture pin
	input wire logic cap_pin,
	// timer side
	pat_cap_if.channel cif
);
	import pat_pkg::*;

	typedef struct packed {
		logic [2:0] sync;
		logic flag;
		logic [7:0] data;
	} pat_cap_state_t;

	pat_cap_state_t st_ff;
	pat_cap_state_t nxt_st;
	logic edge_seen;
	logic take;

	// ===========================================
	// capture logic
	always_comb begin
		nxt_st = st_ff;
		// sync[0] feeds only sync[1]; sync[2] holds the previous level
		nxt_st.sync = {st_ff.sync[1:0], cap_pin};
		edge_seen = cif.rise_sel ? (st_ff.sync[1] & ~st_ff.sync[2])
			: (~st_ff.sync[1] & st_ff.sync[2]);
		// a pending value is not overwritten until software reads it
		take = edge_seen & (~st_ff.flag | cif.rd_clr);
		if (cif.rd_clr) begin
			nxt_st.flag = 1'b0;
		end
		// a capture in the read cycle sets the flag again
		if (take) begin
			nxt_st.flag = 1'b1;
			nxt_st.data = cif.count;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cif.flag = st_ff.flag;
	assign cif.data = st_ff.data;

	// ===========================================
	// checks
	a_cap_hold: assert property (@(posedge clock) disable iff (!reset_n)
		st_ff.flag && !cif.rd_clr |=> $stable(st_ff.data))
		else $error("capture value changed while pending");
	a_cap_take: assert property (@(posedge clock) disable iff (!reset_n)
		!st_ff.flag && cif.rise_sel && st_ff.sync[1] && !st_ff.sync[2]
		|=> st_ff.flag && st_ff.data == $past(cif.count))
		else $error("rising edge not captured");
	a_cap_clear: assert property (@(posedge clock) disable iff (!reset_n)
		cif.rd_clr && !edge_seen |=> !st_ff.flag)
		else $error("capture flag not cleared by read");
endmodule

/* File: logic/pat_timer.sv */
// 8-bit auto-reload timer with four pwm channels and two input captures
//
// Behaviour
// - prescaler input is the cpu clock, or the external clock when selected.
// - counter rate is prescaler input divided by two to the divide field.
// - with counting disabled prescaler and counter stay frozen.
// - force reload copies reload value to counter, clears prescaler, reads zero.
// - overflow interrupt asserted only while its enable and the flag are set.
// - overflow flag set on wrap past FFh, cleared by reading control/status.
// - counter register reads the live count; writes load it at once.
// - on overflow the counter takes the reload value; pwm levels switch.
// - each output enable connects its pwm channel to its pin.
// - pwm is high while count at or below compare; polarity inverts.
// - a polarity change inverts the pwm output immediately.
// - duty register sets the second edge; reload value sets the first.
// - top two capture control/status bits read zero.
// - edge select 0 captures on falling edge, 1 on rising edge.
// - each capture interrupt asserted only while its enable is set.
// - capture flag set on capture, cleared by reading that capture register.
// - capture register holds the count at the capture; writes ignored.
// - reset clears every register to 00h.
// - counter increments once per prescaler output tick while enabled.
// - hidden compare values reload from duty registers at each overflow.
// - further captures are blocked until the capture register is read.
`timescale 1ns/10ps
module pat_timer (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire logic [pat_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pat_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pat_pkg::DATA_W-1:0] reg_rdata,
	// external event clock and capture pins
	input wire logic ext_clock_in,
	input wire logic [pat_pkg::NUM_CAP-1:0] capture_input_pin,
	// pwm pins
	output logic [pat_pkg::NUM_PWM-1:0] pwm_output_pin,
	output logic [pat_pkg::NUM_PWM-1:0] pwm_output_oe,
	// interrupt requests
	output logic overflow_irq,
	output logic [pat_pkg::NUM_CAP-1:0] capture_irq
);
	import pat_pkg::*;

	typedef struct packed {
		logic [7:0] rdata;
		logic ext_clock_select;
		logic [2:0] clock_divide_sel;
		logic counter_enable;
		logic overflow_irq_enable;
		logic overflow_flag;
		logic [7:0] cnt;
		logic [PRESC_W-1:0] presc;
		logic [7:0] reload_data;
		logic [NUM_PWM-1:0][7:0] duty_data;
		logic [NUM_PWM-1:0][7:0] compare;
		logic [NUM_PWM-1:0] oe;
		logic [NUM_PWM-1:0] pwm_polarity;
		logic [NUM_CAP-1:0] cap_edge;
		logic [NUM_CAP-1:0] capture_irq_enable;
		logic [2:0] ext_sync;
		logic [NUM_PWM-1:0] pin;
		logic [NUM_PWM-1:0] pin_oe;
		logic ovf_irq;
		logic [NUM_CAP-1:0] cap_irq;
	} pat_state_t;

	// duty register i sits at this offset
	localparam logic [NUM_PWM-1:0][7:0] OFF_DUTY = {OFF_DUTY3, OFF_DUTY2, OFF_DUTY1, OFF_DUTY0};
	localparam logic [NUM_CAP-1:0][7:0] OFF_CAP = {OFF_CAP2, OFF_CAP1};

	pat_state_t st_ff;
	pat_state_t nxt_st;
	logic in_tick;
	logic [PRESC_W-1:0] tap_mask;
	logic cnt_tick;
	logic ovf_evt;
	logic cnt_load;
	logic tcs_rd;
	logic [NUM_PWM-1:0] level;
	logic [NUM_CAP-1:0] cap_flag;
	logic [NUM_CAP-1:0][7:0] cap_data;

	// ===========================================
	// capture channels
	for (genvar i = 0; i < NUM_CAP; i++) begin : g_cap
		pat_cap_if cif();
		assign cif.count = st_ff.cnt;
		assign cif.rise_sel = st_ff.cap_edge[i];
		assign cif.rd_clr = reg_rd && (reg_addr == OFF_CAP[i]);
		assign cap_flag[i] = cif.flag;
		assign cap_data[i] = cif.data;
		pat_capture u_cap (
			.clock(clock),
			.reset_n(reset_n),
			.cap_pin(capture_input_pin[i]),
			.cif(cif)
		);
	end

	// ===========================================
	// counter, prescaler, registers
	always_comb begin
		nxt_st = st_ff;
		// the event clock is oversampled, so it must run well below the cpu clock
		nxt_st.ext_sync = {st_ff.ext_sync[1:0], ext_clock_in};
		in_tick = st_ff.ext_clock_select ?
			(st_ff.ext_sync[1] & ~st_ff.ext_sync[2]) : 1'b1;
		tap_mask = ~(7'h7F << st_ff.clock_divide_sel);
		cnt_tick = st_ff.counter_enable & in_tick
			& ((st_ff.presc & tap_mask) == tap_mask);
		ovf_evt = cnt_tick & (st_ff.cnt == CNT_MAX);
		cnt_load = reg_wr && ((reg_addr == OFF_CNT)
			|| ((reg_addr == OFF_TCS) && reg_wdata[FRC_BIT]));
		tcs_rd = reg_rd && (reg_addr == OFF_TCS);

		if (st_ff.counter_enable && in_tick) begin
			nxt_st.presc = st_ff.presc + 7'h01;
		end
		if (cnt_tick) begin
			nxt_st.cnt = ovf_evt ? st_ff.reload_data : st_ff.cnt + 8'h01;
		end
		if (ovf_evt) begin
			nxt_st.compare = st_ff.duty_data;
		end

		// a read of the status clears the flag, but a wrap in the same cycle wins
		if (tcs_rd) begin
			nxt_st.overflow_flag = 1'b0;
		end
		if (ovf_evt) begin
			nxt_st.overflow_flag = 1'b1;
		end

		// software writes take priority over the count
		if (reg_wr) begin
			case (reg_addr)
				OFF_TCS: begin
					nxt_st.ext_clock_select = reg_wdata[EXT_SEL_BIT];
					nxt_st.clock_divide_sel = reg_wdata[DIV_LSB+:3];
					nxt_st.counter_enable = reg_wdata[EN_BIT];
					nxt_st.overflow_irq_enable = reg_wdata[OIE_BIT];
					if (reg_wdata[FRC_BIT]) begin
						nxt_st.cnt = st_ff.reload_data;
						nxt_st.presc = '0;
					end
				end
				OFF_CNT: begin
					nxt_st.cnt = reg_wdata;
					nxt_st.presc = '0;
				end
				OFF_RELOAD: begin
					nxt_st.reload_data = reg_wdata;
				end
				OFF_PWMCTL: begin
					nxt_st.oe = reg_wdata[OE_LSB+:NUM_PWM];
					nxt_st.pwm_polarity = reg_wdata[POL_LSB+:NUM_PWM];
				end
				OFF_CCS: begin
					nxt_st.cap_edge = reg_wdata[CS_LSB+:NUM_CAP];
					nxt_st.capture_irq_enable = reg_wdata[CIE_LSB+:NUM_CAP];
				end
				default: begin
				end
			endcase
			for (int i = 0; i < NUM_PWM; i++) begin
				if (reg_addr == OFF_DUTY[i]) begin
					nxt_st.duty_data[i] = reg_wdata;
				end
			end
		end

		// read data stand in the cycle after the strobe, zero otherwise
		nxt_st.rdata = RESET_BYTE;
		if (reg_rd) begin
			case (reg_addr)
				OFF_TCS: begin
					nxt_st.rdata = {st_ff.ext_clock_select, st_ff.clock_divide_sel,
						st_ff.counter_enable, 1'b0, st_ff.overflow_irq_enable,
						st_ff.overflow_flag};
				end
				OFF_CNT: nxt_st.rdata = st_ff.cnt;
				OFF_RELOAD: nxt_st.rdata = st_ff.reload_data;
				OFF_PWMCTL: nxt_st.rdata = {st_ff.oe, st_ff.pwm_polarity};
				OFF_CCS: begin
					nxt_st.rdata = {2'b00, st_ff.cap_edge, st_ff.capture_irq_enable,
						cap_flag};
				end
				OFF_CAP1: nxt_st.rdata = cap_data[0];
				OFF_CAP2: nxt_st.rdata = cap_data[1];
				default: begin
				end
			endcase
			for (int i = 0; i < NUM_PWM; i++) begin
				if (reg_addr == OFF_DUTY[i]) begin
					nxt_st.rdata = st_ff.duty_data[i];
				end
			end
		end

		// level is a pure function of count, compare and polarity, so the
		// overflow switch and a polarity flip both show at once
		for (int i = 0; i < NUM_PWM; i++) begin
			level[i] = (st_ff.cnt <= st_ff.compare[i]) ^ st_ff.pwm_polarity[i];
		end
		nxt_st.pin = st_ff.oe & level;
		nxt_st.pin_oe = st_ff.oe;
		nxt_st.ovf_irq = st_ff.overflow_irq_enable & st_ff.overflow_flag;
		nxt_st.cap_irq = st_ff.capture_irq_enable & cap_flag;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign pwm_output_pin = st_ff.pin;
	assign pwm_output_oe = st_ff.pin_oe;
	assign overflow_irq = st_ff.ovf_irq;
	assign capture_irq = st_ff.cap_irq;

	// ===========================================
	// checks
	a_force_reload: assert property (@(posedge clock) disable iff (!reset_n)
		reg_wr && reg_addr == OFF_TCS && reg_wdata[FRC_BIT]
		|=> st_ff.cnt == $past(st_ff.reload_data) && st_ff.presc == '0)
		else $error("force reload did not load counter");
	a_force_rdzero: assert property (@(posedge clock) disable iff (!reset_n)
		tcs_rd |=> reg_rdata[FRC_BIT] == 1'b0)
		else $error("force reload bit read as one");
	a_ovf_irq: assert property (@(posedge clock) disable iff (!reset_n)
		st_ff.overflow_flag && st_ff.overflow_irq_enable |=> overflow_irq)
		else $error("overflow interrupt missing");
	a_ovf_wrap: assert property (@(posedge clock) disable iff (!reset_n)
		ovf_evt && !cnt_load
		|=> st_ff.cnt == $past(st_ff.reload_data) && st_ff.overflow_flag
		&& st_ff.compare == $past(st_ff.duty_data))
		else $error("overflow did not reload");
	a_ovf_clear: assert property (@(posedge clock) disable iff (!reset_n)
		tcs_rd && !ovf_evt |=> !st_ff.overflow_flag)
		else $error("status read did not clear overflow");
	a_cnt_frozen: assert property (@(posedge clock) disable iff (!reset_n)
		!st_ff.counter_enable && !reg_wr |=> $stable(st_ff.cnt) && $stable(st_ff.presc))
		else $error("counter moved while disabled");
	a_cnt_write: assert property (@(posedge clock) disable iff (!reset_n)
		reg_wr && reg_addr == OFF_CNT ##1 reg_rd && reg_addr == OFF_CNT && !cnt_tick
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("counter write not seen on read back");
	a_pwm_oe: assert property (@(posedge clock) disable iff (!reset_n)
		reg_wr && reg_addr == OFF_PWMCTL |=> ##1 pwm_output_oe == $past(reg_wdata[7:4], 2))
		else $error("output enable not applied");
	a_ccs_rsvd: assert property (@(posedge clock) disable iff (!reset_n)
		reg_rd && reg_addr == OFF_CCS |=> reg_rdata[7:6] == 2'b00)
		else $error("reserved capture bits not zero");

	// ===========================================
	// clock source and divider checks
	// the cpu clock feeds the prescaler on every cycle unless software intervenes
	a_cpu_clock: assert property (@(posedge clock) disable iff (!reset_n)
		!st_ff.ext_clock_select && st_ff.counter_enable && !reg_wr
		|=> st_ff.presc == $past(st_ff.presc) + 7'h01)
		else $error("prescaler missed a cpu clock");
	// with the event clock selected, nothing moves between synchronised rises
	a_ext_idle: assert property (@(posedge clock) disable iff (!reset_n)
		st_ff.ext_clock_select && !(st_ff.ext_sync[1] && !st_ff.ext_sync[2]) && !reg_wr
		|=> $stable(st_ff.presc) && $stable(st_ff.cnt))
		else $error("counter moved without an event clock edge");
	// a wrap counts as the step: the reload value replaces the count
	a_div0_step: assert property (@(posedge clock) disable iff (!reset_n)
		st_ff.counter_enable && in_tick && !reg_wr && st_ff.clock_divide_sel == 3'h0
		|=> st_ff.cnt == (($past(st_ff.cnt) == CNT_MAX) ? $past(st_ff.reload_data)
		: $past(st_ff.cnt) + 8'h01))
		else $error("counter did not step on an undivided tick");
	// any divide above one needs the lowest prescaler bit set before a step
	a_div_gap: assert property (@(posedge clock) disable iff (!reset_n)
		st_ff.clock_divide_sel != 3'h0 && !st_ff.presc[0] && !reg_wr
		|=> $stable(st_ff.cnt))
		else $error("counter stepped between divider taps");

	// ===========================================
	// overflow flag, interrupt and register checks
	// the request lags the flag by one registered stage
	a_ovf_irq_off: assert property (@(posedge clock) disable iff (!reset_n)
		!(st_ff.overflow_flag && st_ff.overflow_irq_enable) |=> !overflow_irq)
		else $error("overflow interrupt without enable and flag");
	// only a wrap may raise the flag; software cannot write it
	a_ovf_rise: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(st_ff.overflow_flag) |-> $past(ovf_evt))
		else $error("overflow flag rose without a wrap");
	a_flag_nowrite: assert property (@(posedge clock) disable iff (!reset_n)
		reg_wr && reg_addr == OFF_TCS && !ovf_evt
		|=> st_ff.overflow_flag == $past(st_ff.overflow_flag))
		else $error("overflow flag followed a software write");
	a_cnt_read: assert property (@(posedge clock) disable iff (!reset_n)
		reg_rd && reg_addr == OFF_CNT |=> reg_rdata == $past(st_ff.cnt))
		else $error("counter read did not return the live count");
	a_reload_write: assert property (@(posedge clock) disable iff (!reset_n)
		reg_wr && reg_addr == OFF_RELOAD |=> st_ff.reload_data == $past(reg_wdata))
		else $error("reload register write lost");
	a_duty_write: assert property (@(posedge clock) disable iff (!reset_n)
		reg_wr && reg_addr == OFF_DUTY0 |=> st_ff.duty_data[0] == $past(reg_wdata))
		else $error("duty register write lost");
	a_ccs_write: assert property (@(posedge clock) disable iff (!reset_n)
		reg_wr && reg_addr == OFF_CCS
		|=> st_ff.cap_edge == $past(reg_wdata[CS_LSB+:NUM_CAP])
		&& st_ff.capture_irq_enable == $past(reg_wdata[CIE_LSB+:NUM_CAP]))
		else $error("capture control write lost");
	// checked from the second edge in reset, as the first may still see power-up state
	a_reset_clear: assert property (@(posedge clock)
		!reset_n ##1 !reset_n |-> st_ff == '0)
		else $error("state not cleared during reset");

	// ===========================================
	// pwm and capture output checks
	a_oe_follow: assert property (@(posedge clock) disable iff (!reset_n)
		reg_wr && reg_addr == OFF_PWMCTL |=> st_ff.oe == $past(reg_wdata[OE_LSB+:NUM_PWM]))
		else $error("output enable write lost");
	a_pwm_gated: assert property (@(posedge clock) disable iff (!reset_n)
		(pwm_output_pin & ~pwm_output_oe) == '0)
		else $error("disabled pwm channel drives its pin");
	// a zero count is at or below any compare value
	a_pwm_zero: assert property (@(posedge clock) disable iff (!reset_n)
		st_ff.cnt == 8'h00 |=> pwm_output_pin == $past(st_ff.oe & ~st_ff.pwm_polarity))
		else $error("pwm level wrong at zero count");
	// with count, compare and enables still, only the flipped channels may toggle
	a_pol_flip: assert property (@(posedge clock) disable iff (!reset_n)
		$changed(st_ff.pwm_polarity) && $stable(st_ff.cnt) && $stable(st_ff.compare)
		&& $stable(st_ff.oe) |=> pwm_output_pin == ($past(pwm_output_pin)
		^ ($past(st_ff.oe) & ($past(st_ff.pwm_polarity) ^ $past(st_ff.pwm_polarity, 2)))))
		else $error("polarity change not applied at once");
	// the double buffer keeps duty writes from reaching the compare mid-period
	a_cmp_hold: assert property (@(posedge clock) disable iff (!reset_n)
		!ovf_evt |=> $stable(st_ff.compare))
		else $error("compare value changed without an overflow");
	// the request follows flag and enable one cycle late
	a_cap_irq_gate: assert property (@(posedge clock) disable iff (!reset_n)
		(capture_irq & ~($past(st_ff.capture_irq_enable) & $past(cap_flag))) == '0)
		else $error("capture interrupt without enable and flag");
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the auto-reload pwm timer and its capture channels
`timescale 1ns/10ps
module tb_top;
	import pat_pkg::*;
	// ===========================================
	// stimulus and observed signals
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic ext_clock_in = 1'b0;
	logic [1:0] capture_input_pin = 2'h0;
	logic [3:0] pwm_output_pin;
	logic [3:0] pwm_output_oe;
	logic overflow_irq;
	logic [1:0] capture_irq;
	logic [7:0] exp_q[$];
	logic rd_pend = 1'b0;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	integer seed = 15240;
	logic [7:0] dch[4];
	logic [7:0] ctl;
	logic [7:0] cnt;
	logic [3:0] pwm_exp;

	always #2.5 clock = ~clock;

	pat_timer DUT (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_clock_in(ext_clock_in), .capture_input_pin(capture_input_pin),
		.pwm_output_pin(pwm_output_pin), .pwm_output_oe(pwm_output_oe),
		.overflow_irq(overflow_irq), .capture_irq(capture_irq));

	// ===========================================
	// comparison, bus cycles and verdict
	task automatic check(input logic [7:0] seen, input logic [7:0] expd);
		n_tests++;
		if (seen !== expd) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, expd);
		end
	endtask

	// strobes stay up between back-to-back calls; idle drops them
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
	endtask

	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge clock);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ===========================================
	// read data stand only in the cycle after the strobe
	always @(posedge clock) begin
		if (rd_pend) begin
			check(reg_rdata, exp_q.pop_front());
		end
		rd_pend <= reg_rd;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			close_out();
		end
	end

	// ===========================================
	// main sequence
	initial begin
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		// whole map plus one unmapped byte on each side
		for (int a = 8'h72; a <= 8'h7E; a++) begin
			rd(8'(a), 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			dch[3-i] = 8'($random(seed));
			wr(OFF_DUTY3 + 8'(i), dch[3-i]);
		end
		for (int i = 0; i < 4; i++) begin
			rd(OFF_DUTY3 + 8'(i), dch[3-i]);
		end
		wr(OFF_CAP1, 8'hA5);
		wr(OFF_CCS, 8'hFF);
		rd(OFF_CAP1, 8'h00);
		rd(OFF_CCS, 8'h3C);
		// compare registers still hold zero until an overflow
		wr(OFF_CCS, 8'h00);
		wr(OFF_PWMCTL, 8'hF0);
		wr(OFF_CNT, 8'h05);
		idle(3);
		check({4'h0, pwm_output_pin}, 8'h00);
		wr(OFF_RELOAD, 8'hF0);
		wr(OFF_TCS, 8'h0E);
		idle(16);
		rd(OFF_TCS, 8'h0B);
		rd(OFF_TCS, 8'h0A);
		check({7'h00, overflow_irq}, 8'h01);
		idle(1);
		check({7'h00, overflow_irq}, 8'h00);
		wr(OFF_TCS, 8'h00);
		for (int k = 0; k < 24; k++) begin
			ctl = 8'($random(seed));
			cnt = (k < 8) ? dch[k%4] + 8'(k/4) : 8'($random(seed));
			wr(OFF_PWMCTL, ctl);
			wr(OFF_CNT, cnt);
			rd(OFF_CNT, cnt);
			idle(3);
			for (int c = 0; c < 4; c++) begin
				pwm_exp[c] = ctl[4+c] & ((cnt <= dch[c]) ^ ctl[c]);
			end
			check({4'h0, pwm_output_pin}, {4'h0, pwm_exp});
			check({4'h0, pwm_output_oe}, {4'h0, ctl[7:4]});
			wr(OFF_PWMCTL, ctl ^ 8'h0F);
			idle(2);
			check({4'h0, pwm_output_pin}, {4'h0, pwm_exp ^ ctl[7:4]});
		end
		idle(20);
		rd(OFF_CNT, cnt);
		// one tick short of the third step at each divide setting
		for (int d = 0; d < 8; d++) begin
			wr(OFF_TCS, {1'b0, 3'(d), 4'h8});
			wr(OFF_CNT, 8'h00);
			idle(3 * (1 << d) - 1);
			rd(OFF_CNT, 8'h02);
		end
		wr(OFF_TCS, 8'h88);
		wr(OFF_CNT, 8'h00);
		repeat (5) begin
			ext_clock_in <= 1'b1;
			idle(4);
			ext_clock_in <= 1'b0;
			idle(4);
		end
		rd(OFF_CNT, 8'h05);
		// ch1 rising, ch2 falling; ch2 rise and ch1 fall must not capture
		wr(OFF_TCS, 8'h00);
		wr(OFF_CCS, 8'h1C);
		wr(OFF_CNT, 8'h42);
		capture_input_pin <= 2'b11;
		idle(6);
		rd(OFF_CCS, 8'h1D);
		check({6'h00, capture_irq}, 8'h01);
		wr(OFF_CNT, 8'h43);
		capture_input_pin <= 2'b00;
		idle(6);
		wr(OFF_CNT, 8'h44);
		capture_input_pin <= 2'b01;
		idle(6);
		check({6'h00, capture_irq}, 8'h03);
		rd(OFF_CAP1, 8'h42);
		rd(OFF_CCS, 8'h1E);
		rd(OFF_CAP2, 8'h43);
		rd(OFF_CCS, 8'h1C);
		idle(3);
		close_out();
	end
endmodule
